// ===== rtl/ivme_cmd_core.sv
// handler vector, return from handler, user function and position-reached command decoder
`timescale 1ns/10ps
module ivme_cmd_core
  import ivme_pkg::*;
#(
  parameter int NUM_IRQ = 16,
  parameter int NUM_MOTORS = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ivme_cmd_t cmd,
  input wire logic irq_take,
  input wire logic [7:0] irq_num,
  input wire ivme_ctx_t cur_ctx,
  input wire logic move_to_position,
  input wire logic [7:0] move_motor,
  input wire logic [NUM_MOTORS-1:0] target_reached,
  output ivme_reply_t reply,
  output logic restore_valid,
  output ivme_ctx_t restore_ctx,
  output logic jump_valid,
  output logic [PC_W-1:0] jump_addr,
  output logic in_handler
);
  typedef struct packed {
    ivme_reply_t reply;
    logic restore_valid;
    logic jump_valid;
    logic [PC_W-1:0] jump_addr;
    ivme_ctx_t saved;
    logic in_handler;
    logic armed;
    logic persist;
    logic [NUM_MOTORS-1:0] mask;
    logic [NUM_MOTORS-1:0] watch;
    logic [NUM_MOTORS-1:0] pend;
  } ivme_core_state_t;

  ivme_core_state_t state_ff;
  ivme_core_state_t nxt_state;
  logic [PC_W-1:0] vec_rd_addr;
  logic vec_wr;
  logic is_define;
  logic is_return;
  logic is_user;
  logic is_req;
  logic take_ok;
  logic [NUM_MOTORS-1:0] reached_now;
  logic [NUM_MOTORS-1:0] move_sel;

  // one-hot motor select, used for both move tracking and its checks
  function automatic logic [NUM_MOTORS-1:0] motor_onehot(input logic [7:0] idx);
    motor_onehot = '0;
    for (int i = 0; i < NUM_MOTORS; i++) begin
      motor_onehot[i] = (idx == 8'(i));
    end
  endfunction

  // opcode decode
  assign is_define = cmd.valid && (cmd.opcode == OP_DEFINE_VECTOR);
  assign is_return = cmd.valid && (cmd.opcode == OP_RETURN_HANDLER);
  assign is_user = cmd.valid && (cmd.opcode >= OP_USER_FIRST) && (cmd.opcode <= OP_USER_LAST);
  // a stored program cannot issue the position-reached request
  assign is_req = cmd.valid && cmd.direct && (cmd.opcode == OP_REACHED_REQ);
  assign vec_wr = is_define;
  // nesting is not supported: one saved context, so a take while in a handler is dropped, not queued
  assign take_ok = irq_take && !state_ff.in_handler;
  assign move_sel = motor_onehot(move_motor);
  assign reached_now = target_reached & state_ff.watch;

  ivme_vector_table #(
    .NUM_IRQ(NUM_IRQ)
  ) u_vectors (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(vec_wr),
    .wr_idx(cmd.typ),
    .wr_addr(cmd.value[PC_W-1:0]),
    .rd_idx(irq_num),
    .rd_addr(vec_rd_addr)
  );

  // next-state logic for replies, handler context and motion reporting
  always_comb begin
    nxt_state = state_ff;
    nxt_state.reply = '0;
    nxt_state.restore_valid = 1'b0;
    nxt_state.jump_valid = 1'b0;
    // interrupt entry: save context, jump to vector
    if (take_ok) begin
      nxt_state.saved = cur_ctx;
      nxt_state.jump_valid = 1'b1;
      nxt_state.jump_addr = vec_rd_addr;
      nxt_state.in_handler = 1'b1;
    end
    // return from handler hands the saved context back
    if (is_return && state_ff.in_handler) begin
      nxt_state.restore_valid = 1'b1;
      nxt_state.in_handler = 1'b0;
    end
    // position-reached request arms reporting
    if (is_req) begin
      nxt_state.armed = 1'b1;
      nxt_state.mask = cmd.value[NUM_MOTORS-1:0];
      nxt_state.persist = (cmd.typ == TYPE_PERSIST);
    end else if (move_to_position && state_ff.armed) begin
      nxt_state.watch = state_ff.watch | (move_sel & state_ff.mask);
      if (!state_ff.persist) begin
        nxt_state.armed = 1'b0;
      end
    end
    // arrivals stop watching and queue a delayed report
    nxt_state.watch = nxt_state.watch & ~reached_now;
    nxt_state.pend = state_ff.pend | reached_now;
    // immediate replies, direct link only
    if (cmd.valid && cmd.direct && (is_define || is_return || is_user || is_req)) begin
      nxt_state.reply.valid = 1'b1;
      nxt_state.reply.status = ST_OK;
      nxt_state.reply.command = cmd.opcode;
      nxt_state.reply.value = '0;
      if (is_user) begin
        nxt_state.reply.value = USER_REPLY_VALUE;
      end
      if (is_req) begin
        nxt_state.reply.value[NUM_MOTORS-1:0] = cmd.value[NUM_MOTORS-1:0];
      end
    end else if (state_ff.pend != '0) begin
      // delayed report only in a free slot; new arrivals this cycle stay pending
      nxt_state.reply.valid = 1'b1;
      nxt_state.reply.status = ST_REACHED;
      nxt_state.reply.command = OP_REACHED_REQ;
      nxt_state.reply.value = '0;
      nxt_state.reply.value[NUM_MOTORS-1:0] = state_ff.pend;
      nxt_state.pend = reached_now;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs are flop fields
  assign reply = state_ff.reply;
  assign restore_valid = state_ff.restore_valid;
  assign restore_ctx = state_ff.saved;
  assign jump_valid = state_ff.jump_valid;
  assign jump_addr = state_ff.jump_addr;
  assign in_handler = state_ff.in_handler;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_direct_req;
    cmd.valid && cmd.direct && (cmd.opcode == OP_REACHED_REQ);
  endsequence
  sequence s_ok_reply;
    reply.valid && (reply.status == ST_OK);
  endsequence

  a_define_reply_ok: assert property (
    (is_define && cmd.direct) |=> s_ok_reply and (reply.command == OP_DEFINE_VECTOR))
    else $error("define-vector reply not ok");
  a_req_reply_now: assert property (
    s_direct_req |=> s_ok_reply and (reply.command == OP_REACHED_REQ))
    else $error("request reply missing");
  a_user_reply_ok: assert property (
    (is_user && cmd.direct) |=> s_ok_reply)
    else $error("user function reply not ok");
  // a program-sourced request must leave reporting disarmed
  a_prog_req_quiet: assert property (
    (cmd.valid && !cmd.direct && (cmd.opcode == OP_REACHED_REQ) && !state_ff.armed)
      |=> !state_ff.armed)
    else $error("program request armed reporting");
  // program commands get no immediate reply; only a queued report may use the slot
  a_prog_silent: assert property (
    (cmd.valid && !cmd.direct && (state_ff.pend == '0)) |=> !reply.valid)
    else $error("program command was answered");
  a_return_restores: assert property (
    (take_ok ##1 (!irq_take && !is_return) [*1] ##1 (is_return && !irq_take))
      |=> restore_valid && (restore_ctx == $past(cur_ctx, 3)) && !in_handler)
    else $error("return did not restore saved context");
  a_return_idle: assert property (
    (is_return && !state_ff.in_handler && !irq_take) |=> !restore_valid && !in_handler)
    else $error("return outside a handler restored context");
  a_take_jumps: assert property (
    take_ok |=> jump_valid && in_handler)
    else $error("interrupt entry missing jump");
  // only one saved context, so a take inside a handler must not overwrite it
  a_take_ignored: assert property (
    (irq_take && state_ff.in_handler && !is_return) |=> !jump_valid && $stable(restore_ctx))
    else $error("nested interrupt was taken");
  a_oneshot_disarm: assert property (
    (state_ff.armed && !state_ff.persist && move_to_position && !is_req) |=> !state_ff.armed)
    else $error("one-shot reporting stayed armed");
  a_persist_keeps: assert property (
    (state_ff.armed && state_ff.persist && move_to_position && !is_req) |=> state_ff.armed)
    else $error("persistent reporting disarmed");
  // a move on a masked motor while armed must start watching that motor
  a_watch_masked: assert property (
    (state_ff.armed && move_to_position && !is_req && ((move_sel & state_ff.mask) != '0)
      && ((target_reached & move_sel) == '0))
      |=> ((state_ff.watch & $past(move_sel)) != '0))
    else $error("masked motor not watched");
  a_reach_report: assert property (
    ((reached_now != '0) && !cmd.valid) ##1 !cmd.valid
      |=> reply.valid && (reply.status == ST_REACHED) && (reply.command == OP_REACHED_REQ))
    else $error("delayed report missing");
endmodule

// ===== rtl/ivme_pkg.sv
// shared constants and carrier types for the handler vector and move event command block
package ivme_pkg;
  localparam int DATA_W = 32;
  localparam int PC_W = 16;
  localparam int FLAG_W = 8;
  localparam int MASK_BYTE_W = 8;
  // instruction numbers handled here
  localparam logic [7:0] OP_DEFINE_VECTOR = 8'h25;
  localparam logic [7:0] OP_RETURN_HANDLER = 8'h26;
  localparam logic [7:0] OP_USER_FIRST = 8'h40;
  localparam logic [7:0] OP_USER_LAST = 8'h47;
  localparam logic [7:0] OP_REACHED_REQ = 8'h8a;
  // reply status codes
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_REACHED = 8'h80;
  // type field value that keeps reporting armed
  localparam logic [7:0] TYPE_PERSIST = 8'h01;
  localparam logic [DATA_W-1:0] USER_REPLY_VALUE = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic direct;
    logic [7:0] opcode;
    logic [7:0] typ;
    logic [7:0] motor;
    logic [DATA_W-1:0] value;
  } ivme_cmd_t;

  typedef struct packed {
    logic valid;
    logic [7:0] status;
    logic [7:0] command;
    logic [DATA_W-1:0] value;
  } ivme_reply_t;

  typedef struct packed {
    logic [DATA_W-1:0] accu;
    logic [DATA_W-1:0] xreg;
    logic [FLAG_W-1:0] flags;
    logic [PC_W-1:0] pc;
  } ivme_ctx_t;
endpackage

// ===== rtl/ivme_vector_table.sv
// handler entry address table, one flip-flop word per interrupt number
`timescale 1ns/10ps
module ivme_vector_table
  import ivme_pkg::*;
#(
  parameter int NUM_IRQ = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [PC_W-1:0] wr_addr,
  input wire logic [7:0] rd_idx,
  output logic [PC_W-1:0] rd_addr
);
  typedef struct packed {
    logic [NUM_IRQ-1:0][PC_W-1:0] vec;
  } ivme_vt_state_t;

  ivme_vt_state_t state_ff;
  ivme_vt_state_t nxt_state;

  // a later write to the same index simply overwrites the entry
  always_comb begin
    nxt_state = state_ff;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (wr_en && (wr_idx == 8'(i))) begin
        nxt_state.vec[i] = wr_addr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // indices beyond the table read as address zero
  always_comb begin
    rd_addr = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (rd_idx == 8'(i)) begin
        rd_addr = state_ff.vec[i];
      end
    end
  end
endmodule

// ===== dv/ivme_host_model.sv
// host-side model that presents commands to the block one at a time
`timescale 1ns/10ps
module ivme_host_model
  import ivme_pkg::*;
(
  input wire logic clk,
  output ivme_cmd_t cmd
);
  initial cmd = '0;
  // one cycle of valid, launched on the falling edge; the host only sends
  // the reached request from the link unless a scenario means it
  task automatic send(input logic drct, input logic [7:0] op, input logic [7:0] ty,
      input logic [31:0] val);
    @(negedge clk);
    cmd <= '{1'b1, drct, op, ty, 8'h00, val};
    @(negedge clk);
    // the released value field turns over so a stale value is never read as good
    cmd.valid <= 1'b0;
    cmd.value <= ~val;
  endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the handler vector and move event command block
`timescale 1ns/10ps
module tb_top;
  import ivme_pkg::*;
  logic clk;
  logic rst_n;
  ivme_cmd_t cmd;
  logic irq_take;
  logic [7:0] irq_num;
  ivme_ctx_t cur_ctx;
  logic move_to_position;
  logic [7:0] move_motor;
  logic [2:0] target_reached;
  ivme_reply_t reply;
  logic restore_valid;
  ivme_ctx_t restore_ctx;
  logic jump_valid;
  logic [PC_W-1:0] jump_addr;
  logic in_handler;
  ivme_ctx_t ctx_a;
  int err_total;
  int num_checks;

  ivme_host_model host (.clk(clk), .cmd(cmd));
  ivme_cmd_core #(.NUM_IRQ(16), .NUM_MOTORS(3)) uut (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .irq_take(irq_take), .irq_num(irq_num),
    .cur_ctx(cur_ctx), .move_to_position(move_to_position), .move_motor(move_motor),
    .target_reached(target_reached), .reply(reply), .restore_valid(restore_valid),
    .restore_ctx(restore_ctx), .jump_valid(jump_valid), .jump_addr(jump_addr),
    .in_handler(in_handler));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [48:0] rv();
    return {reply.valid, reply.status, reply.command, reply.value};
  endfunction

  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // define, redefine from a program, then take the interrupt
  task automatic t_vector;
    host.send(1'b1, OP_DEFINE_VECTOR, 8'h03, 32'h0000_0032);
    chk(rv() >> 32, {1'b1, ST_OK, OP_DEFINE_VECTOR});
    host.send(1'b0, OP_DEFINE_VECTOR, 8'h03, 32'h0000_1234);
    chk(reply.valid, 1'b0);
    irq_num <= 8'h03;
    irq_take <= 1'b1;
    @(negedge clk);
    irq_take <= 1'b0;
    cur_ctx <= ~ctx_a;
    chk({jump_valid, in_handler, jump_addr}, {2'b11, 16'h1234});
    chk(restore_ctx, ctx_a);
  endtask

  // return while in a handler, then once more with none active
  task automatic t_return;
    host.send(1'b1, OP_RETURN_HANDLER, 8'hff, 32'h0);
    chk(rv() >> 32, {1'b1, ST_OK, OP_RETURN_HANDLER});
    chk({restore_valid, in_handler, restore_ctx}, {2'b10, ctx_a});
    host.send(1'b1, OP_RETURN_HANDLER, 8'hff, 32'h0);
    chk({reply.valid, restore_valid}, 2'b10);
  endtask

  // every user function opcode answers ok
  task automatic t_user;
    for (int i = 0; i < 8; i++) begin
      host.send(1'b1, OP_USER_FIRST + 8'(i), 8'h00, 32'h0);
      chk(rv(), {1'b1, ST_OK, OP_USER_FIRST + 8'(i), USER_REPLY_VALUE});
    end
  endtask

  task automatic mv(input logic [7:0] m);
    @(negedge clk);
    move_to_position <= 1'b1;
    move_motor <= m;
    @(negedge clk);
    move_to_position <= 1'b0;
    move_motor <= ~m;
  endtask

  task automatic reach(input logic [2:0] m);
    @(negedge clk);
    target_reached <= m;
    @(negedge clk);
    target_reached <= 3'h0;
  endtask

  // bounded wait; a zero mask means no report may appear
  task automatic wait_rep(input logic [2:0] m);
    for (int i = 0; i < 20 && reply.valid !== 1'b1; i++) @(negedge clk);
    if (m == 3'h0)
      chk(reply.valid, 1'b0);
    else
      chk(rv(), {1'b1, ST_REACHED, OP_REACHED_REQ, 29'h0, m});
  endtask

  // program-sourced request is ignored; one-shot watches only the next move
  task automatic t_oneshot;
    host.send(1'b0, OP_REACHED_REQ, 8'h01, 32'h7);
    chk(reply.valid, 1'b0);
    host.send(1'b1, OP_REACHED_REQ, 8'h00, 32'h5);
    chk(rv(), {1'b1, ST_OK, OP_REACHED_REQ, 32'h5});
    mv(8'h00);
    reach(3'h1);
    wait_rep(3'h1);
    mv(8'h02);
    reach(3'h4);
    wait_rep(3'h0);
  endtask

  // persistent setting reports every move of the selected motor
  task automatic t_persist;
    host.send(1'b1, OP_REACHED_REQ, TYPE_PERSIST, 32'h2);
    chk(rv(), {1'b1, ST_OK, OP_REACHED_REQ, 32'h2});
    for (int i = 0; i < 2; i++) begin
      mv(8'h01);
      reach(3'h2);
      wait_rep(3'h2);
    end
  endtask

  // a take inside a handler is ignored; an out-of-range number jumps to zero
  task automatic t_nested;
    @(negedge clk);
    cur_ctx <= ctx_a;
    irq_num <= 8'h20;
    irq_take <= 1'b1;
    @(negedge clk);
    cur_ctx <= ~ctx_a;
    irq_num <= 8'h03;
    chk({jump_valid, in_handler, jump_addr}, {2'b11, 16'h0000});
    @(negedge clk);
    irq_take <= 1'b0;
    chk({jump_valid, in_handler, restore_ctx}, {2'b01, ctx_a});
    host.send(1'b1, OP_RETURN_HANDLER, 8'hff, 32'h0);
    chk({restore_valid, in_handler, restore_ctx}, {2'b10, ctx_a});
  endtask

  // the run should take well under a thousand cycles
  initial begin
    #100us;
    err_total++;
    end_sim();
  end

  initial begin
    err_total = 0;
    num_checks = 0;
    ctx_a = '{32'h1111_2222, 32'h3333_4444, 8'h5a, 16'h0077};
    rst_n = 1'b0;
    irq_take = 1'b0;
    irq_num = 8'h00;
    cur_ctx = ctx_a;
    move_to_position = 1'b0;
    move_motor = 8'h00;
    target_reached = 3'h0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n <= 1'b1;
    t_vector();
    t_return();
    t_user();
    t_oneshot();
    t_persist();
    t_nested();
    end_sim();
  end
endmodule
